/* File: ac_source.sv */
// Behavioural AC source seen through the series resistor at the crossing pin
`timescale 1ns/1ns
`default_nettype none
module ac_source (
    input  wire logic above_ref,
    output logic      comp_sink
);
    // Above the reference the stage sinks current; the bench only moves
    // the source right after a clock edge, so the level is never glitchy
    assign comp_sink = above_ref;
endmodule
`default_nettype wire

/* File: crossing_defs.svh */
// Register map, field positions and reset values of the zero-crossing unit
`ifndef CROSSING_DEFS_SVH
`define CROSSING_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CTRL_IDX 12'h0EC5
`define STAT_IDX 12'h0EC6
`define MASK_IDX 12'h0EC7
`define PMD_IDX 12'h0EC8

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_SOFT_EN_BIT 7
`define CTRL_OUT_BIT 5
`define CTRL_INV_BIT 4
`define CTRL_RISE_BIT 1
`define CTRL_FALL_BIT 0
`define STAT_FLAG_BIT 0
`define PMD_DISABLE_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_RESET 4'h0
`define READ_ZERO 32'h0000_0000

`endif

/* File: crossing_detect.sv */
// Zero-crossing detector logic with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "crossing_defs.svh"
module crossing_detect (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [13:0] av_address,
    input  wire logic        av_read,
    input  wire logic        av_write,
    input  wire logic [31:0] av_writedata,
    input  wire logic [3:0]  av_byteenable,
    output logic      [31:0] av_readdata,
    output logic             av_waitrequest,
    // Analog stage and pin
    input  wire logic        comp_sink,
    input  wire logic        config_fuse,
    output logic             detector_enable,
    output logic             pin_drive_force,
    // Consumers of the logic output
    output logic             crossing_out,
    output logic             timer_gate_src,
    output logic             timer_clk_src,
    output logic             timer_rst_src,
    output logic             irq
);
    // ****************************************************************
    // State
    // ****************************************************************
    crossing_pkg::state_t st_reg;
    crossing_pkg::state_t st_next;

    logic comp_sync;
    logic fuse_sync;
    logic raw_eff;
    logic out_next;
    logic rise_edge;
    logic fall_edge;
    logic flag_set;
    logic flag_clr;
    logic req;
    logic word_ok;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_pmd;
    logic [31:0] read_val;

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    crossing_sync u_comp_sync (
        .clk      (clk),
        .async_in (comp_sink),
        .sync_out (comp_sync)
    );

    crossing_sync u_fuse_sync (
        .clk      (clk),
        .async_in (config_fuse),
        .sync_out (fuse_sync)
    );

    // ****************************************************************
    // Address decode and read mux
    // ****************************************************************
    always_comb begin
        req      = av_read | av_write;
        word_ok  = (av_address[1:0] == 2'h0);
        hit_ctrl = word_ok && (av_address[13:2] == `CTRL_IDX);
        hit_stat = word_ok && (av_address[13:2] == `STAT_IDX);
        hit_mask = word_ok && (av_address[13:2] == `MASK_IDX);
        hit_pmd  = word_ok && (av_address[13:2] == `PMD_IDX);
        read_val = `READ_ZERO;
        if (hit_ctrl) begin
            read_val[`CTRL_SOFT_EN_BIT] = st_reg.ctrl.soft_enable;
            read_val[`CTRL_OUT_BIT]     = st_reg.out;
            read_val[`CTRL_INV_BIT]     = st_reg.ctrl.output_invert;
            read_val[`CTRL_RISE_BIT]    = st_reg.ctrl.rise_irq_en;
            read_val[`CTRL_FALL_BIT]    = st_reg.ctrl.fall_irq_en;
        end else if (hit_stat) begin
            read_val[`STAT_FLAG_BIT] = st_reg.flag;
        end else if (hit_mask) begin
            read_val[`STAT_FLAG_BIT] = st_reg.mask;
        end else if (hit_pmd) begin
            read_val[`PMD_DISABLE_BIT] = st_reg.module_disable;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;

        // Comparator is off while inactive, so the raw level rests low
        raw_eff  = comp_sync & st_reg.active;
        out_next = raw_eff ^ st_reg.ctrl.output_invert;
        // Edges from consecutive adjusted samples, so an invert write
        // alone yields an edge even while soft enable is clear
        rise_edge = out_next & ~st_reg.out;
        fall_edge = ~out_next & st_reg.out;
        flag_set  = (rise_edge & st_reg.ctrl.rise_irq_en)
                  | (fall_edge & st_reg.ctrl.fall_irq_en);
        flag_clr  = 1'b0;

        // No sleep input: detection never pauses
        st_next.out = out_next;

        // Fuse clear wins over both soft enable and module disable
        st_next.active = ~st_reg.fuse
                       | (st_reg.ctrl.soft_enable & ~st_reg.module_disable);
        st_next.pin_force = st_reg.fuse & st_reg.ctrl.soft_enable;

        // Bus: one wait state, data latched when the request is first seen
        if (req && st_reg.waitreq) begin
            st_next.waitreq = 1'b0;
            st_next.rdata   = read_val;
        end else if (req && !st_reg.waitreq) begin
            st_next.waitreq = 1'b1;
            if (av_write && av_byteenable[0]) begin
                if (hit_ctrl) begin
                    st_next.ctrl.soft_enable   = av_writedata[`CTRL_SOFT_EN_BIT];
                    st_next.ctrl.output_invert = av_writedata[`CTRL_INV_BIT];
                    st_next.ctrl.rise_irq_en   = av_writedata[`CTRL_RISE_BIT];
                    st_next.ctrl.fall_irq_en   = av_writedata[`CTRL_FALL_BIT];
                end
                if (hit_mask) begin
                    st_next.mask = av_writedata[`STAT_FLAG_BIT];
                end
                if (hit_pmd) begin
                    st_next.module_disable = av_writedata[`PMD_DISABLE_BIT];
                end
            end
            // Clear only what was returned, so a newer event is never lost
            if (av_read && hit_stat) begin
                flag_clr = st_reg.rdata[`STAT_FLAG_BIT];
            end
        end

        st_next.flag = (st_reg.flag & ~flag_clr) | flag_set;
        st_next.irq  = st_next.flag & st_next.mask;

        if (!rst_n) begin
            st_next                = '0;
            st_next.ctrl           = `CTRL_RESET;
            st_next.waitreq        = 1'b1;
            // Strap is sampled every reset cycle; last value before release holds
            st_next.fuse           = fuse_sync;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign av_readdata     = st_reg.rdata;
    assign av_waitrequest  = st_reg.waitreq;
    assign detector_enable = st_reg.active;
    assign pin_drive_force = st_reg.pin_force;
    assign crossing_out    = st_reg.out;
    assign timer_gate_src  = st_reg.out;
    assign timer_clk_src   = st_reg.out;
    assign timer_rst_src   = st_reg.out;
    assign irq             = st_reg.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sink_reads_high_a: assert property (
        (comp_sync && st_reg.active && !st_reg.ctrl.output_invert) |=> crossing_out)
        else $error("sinking level did not read high");

    invert_output_a: assert property (
        ##1 crossing_out == ($past(raw_eff) ^ $past(st_reg.ctrl.output_invert)))
        else $error("logic output not polarity adjusted");

    rise_sets_flag_a: assert property (
        ($rose(crossing_out) && $past(st_reg.ctrl.rise_irq_en)) |-> st_reg.flag)
        else $error("enabled rising edge did not set flag");

    fall_sets_flag_a: assert property (
        ($fell(crossing_out) && $past(st_reg.ctrl.fall_irq_en)) |-> st_reg.flag)
        else $error("enabled falling edge did not set flag");

    flag_has_cause_a: assert property (
        $rose(st_reg.flag) |-> $changed(crossing_out))
        else $error("flag set without an output edge");

    invert_raises_flag_a: assert property (
        ($changed(st_reg.ctrl.output_invert) && st_reg.ctrl.rise_irq_en
         && st_reg.ctrl.fall_irq_en && !st_reg.ctrl.soft_enable && $stable(raw_eff))
        |=> st_reg.flag)
        else $error("invert change did not raise flag");

    set_wins_a: assert property (
        (flag_set && flag_clr) |=> st_reg.flag)
        else $error("clear beat a same-cycle edge");

    // The release edge itself still shows reset values, so start one cycle later
    enable_logic_a: assert property (
        rst_n |=> detector_enable == (!$past(st_reg.fuse)
            || ($past(st_reg.ctrl.soft_enable) && !$past(st_reg.module_disable))))
        else $error("detector enable wrong");

    fuse_clear_active_a: assert property (
        (rst_n && !st_reg.fuse) |=> detector_enable [*2])
        else $error("detector off with fuse cleared");

    pin_force_a: assert property (
        (st_reg.fuse && st_reg.ctrl.soft_enable) |=> pin_drive_force)
        else $error("pin not forced to drive");

    bus_answer_a: assert property (
        (req && av_waitrequest) |=> !av_waitrequest ##1 av_waitrequest)
        else $error("bus did not answer in one wait state");

    irq_follows_a: assert property (
        irq == (st_reg.flag && st_reg.mask))
        else $error("interrupt level wrong");

    timer_sources_a: assert property (
        (timer_gate_src == crossing_out) && (timer_clk_src == crossing_out)
        && (timer_rst_src == crossing_out))
        else $error("timer source differs from logic output");

    rise_gated_a: assert property (
        ($rose(crossing_out) && !$past(st_reg.ctrl.rise_irq_en) && !$past(st_reg.flag))
        |-> !st_reg.flag)
        else $error("disabled rising edge set flag");

    fall_gated_a: assert property (
        ($fell(crossing_out) && !$past(st_reg.ctrl.fall_irq_en) && !$past(st_reg.flag))
        |-> !st_reg.flag)
        else $error("disabled falling edge set flag");

    flag_read_clear_a: assert property (
        $fell(st_reg.flag) |-> $past(av_read && hit_stat && !av_waitrequest))
        else $error("flag cleared without a status read");

    fuse_set_idle_a: assert property (
        (rst_n && st_reg.fuse && !st_reg.ctrl.soft_enable) |=> !detector_enable)
        else $error("detector on with fuse set and soft enable clear");

    rise_irq_c: cover property ($rose(crossing_out) && st_reg.ctrl.rise_irq_en ##1 irq);
    fall_irq_c: cover property ($fell(crossing_out) && st_next.flag);
    invert_irq_c: cover property ($changed(st_reg.ctrl.output_invert) ##1 $rose(st_reg.flag));
    read_clear_c: cover property (flag_clr ##1 !st_reg.flag);
    set_wins_c: cover property (flag_set && flag_clr);
endmodule
`default_nettype wire

/* File: crossing_pkg.sv */
// Types shared by the zero-crossing unit
`default_nettype none
package crossing_pkg;

    // Software-written control fields
    typedef struct packed {
        logic soft_enable;
        logic output_invert;
        logic rise_irq_en;
        logic fall_irq_en;
    } ctrl_t;

    // All state of the detector top
    typedef struct packed {
        ctrl_t       ctrl;
        logic        module_disable;
        logic        fuse;
        logic        flag;
        logic        mask;
        logic        out;
        logic        active;
        logic        pin_force;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
    } state_t;

    // Synchroniser stages
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

endpackage
`default_nettype wire

/* File: crossing_sync.sv */
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module crossing_sync (
    input  wire logic clk,
    input  wire logic async_in,
    output logic      sync_out
);
    crossing_pkg::sync_state_t st_reg;
    crossing_pkg::sync_state_t st_next;

    // No reset: the chain must carry the strap level through reset itself
    always_comb begin
        st_next      = st_reg;
        st_next.meta = async_in;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign sync_out = st_reg.sync;
endmodule
`default_nettype wire

/* File: tb_crossing_detect.sv */
// Self-checking bench for the zero-crossing detector
`timescale 1ns/1ns
`default_nettype none
`include "crossing_defs.svh"
module tb_crossing_detect;
    logic        clk;
    logic        rst_n;
    logic [13:0] av_address;
    logic        av_read;
    logic        av_write;
    logic [31:0] av_writedata;
    logic [3:0]  av_byteenable;
    logic [31:0] av_readdata;
    logic        av_waitrequest;
    logic        comp_sink;
    logic        above_ref;
    logic        config_fuse;
    logic        detector_enable;
    logic        pin_drive_force;
    logic        crossing_out;
    logic        timer_gate_src;
    logic        timer_clk_src;
    logic        timer_rst_src;
    logic        irq;
    integer      err_count;
    integer      comparisons;
    logic [31:0] rd;

    crossing_detect dut (.clk(clk), .rst_n(rst_n), .av_address(av_address),
        .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
        .av_byteenable(av_byteenable), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .comp_sink(comp_sink),
        .config_fuse(config_fuse), .detector_enable(detector_enable),
        .pin_drive_force(pin_drive_force), .crossing_out(crossing_out),
        .timer_gate_src(timer_gate_src), .timer_clk_src(timer_clk_src),
        .timer_rst_src(timer_rst_src), .irq(irq));
    ac_source src (.above_ref(above_ref), .comp_sink(comp_sink));

    always #10 clk = ~clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_count = err_count + 1;
        end
    endtask

    task check_bit(input string what, input logic exp, input logic got);
        check(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
    endtask

    // Holds the request until waitrequest is sampled low, then lets one edge pass
    task xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        integer n;
        n = 0;
        av_address <= {idx, 2'b00};
        av_writedata <= {24'h00_0000, d};
        av_byteenable <= 4'hf;
        av_write <= wr;
        av_read <= ~wr;
        @(posedge clk);
        while (av_waitrequest !== 1'b0) begin
            n = n + 1;
            if (n > 20) begin
                err_count = err_count + 1;
                give_verdict();
            end
            @(posedge clk);
        end
        rd = av_readdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
        @(posedge clk);
    endtask

    task reg_is(input logic [11:0] idx, input logic [31:0] exp, input string what);
        xfer(1'b0, idx, 8'h00);
        check(what, exp, rd);
    endtask

    task do_reset(input logic fuse);
        config_fuse <= fuse;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task settle;
        repeat (5) @(posedge clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset_values;
        do_reset(1'b0);
        check_bit("det_en", 1'b1, detector_enable);
        check_bit("pin_force", 1'b0, pin_drive_force);
        reg_is(`CTRL_IDX, 32'h0000_0000, "ctrl");
        reg_is(`MASK_IDX, 32'h0000_0000, "mask");
        reg_is(12'h0ED0, 32'h0000_0000, "unmapped");
        $display("test reset_values done");
    endtask

    task t_edges;
        xfer(1'b1, `MASK_IDX, 8'h01);
        xfer(1'b1, `CTRL_IDX, 8'h02);
        above_ref <= 1'b1;
        settle();
        check_bit("out", 1'b1, crossing_out);
        check_bit("gate", 1'b1, timer_gate_src);
        check_bit("tclk", 1'b1, timer_clk_src);
        check_bit("trst", 1'b1, timer_rst_src);
        check_bit("irq", 1'b1, irq);
        reg_is(`CTRL_IDX, 32'h0000_0022, "ctrl_out");
        reg_is(`STAT_IDX, 32'h0000_0001, "flag_rise");
        reg_is(`STAT_IDX, 32'h0000_0000, "flag_clr");
        check_bit("irq_clr", 1'b0, irq);
        above_ref <= 1'b0;
        settle();
        reg_is(`STAT_IDX, 32'h0000_0000, "fall_off");
        xfer(1'b1, `CTRL_IDX, 8'h01);
        above_ref <= 1'b1;
        settle();
        reg_is(`STAT_IDX, 32'h0000_0000, "rise_off");
        above_ref <= 1'b0;
        settle();
        reg_is(`STAT_IDX, 32'h0000_0001, "flag_fall");
        $display("test edges done");
    endtask

    task t_invert;
        xfer(1'b1, `MASK_IDX, 8'h00);
        xfer(1'b1, `CTRL_IDX, 8'h12);
        settle();
        check_bit("out_inv", 1'b1, crossing_out);
        check_bit("irq_masked", 1'b0, irq);
        reg_is(`CTRL_IDX, 32'h0000_0032, "ctrl_inv");
        reg_is(`STAT_IDX, 32'h0000_0001, "flag_pol");
        above_ref <= 1'b1;
        settle();
        reg_is(`STAT_IDX, 32'h0000_0000, "adj_fall");
        $display("test invert done");
    endtask

    // The edge lands on the very edge that completes the clearing read
    task t_race;
        // Invert falls with the pin high: the rising output edge sets the flag
        xfer(1'b1, `CTRL_IDX, 8'h03);
        settle();
        // Falling output edge arrives three edges on, as the read completes
        above_ref <= 1'b0;
        @(posedge clk);
        reg_is(`STAT_IDX, 32'h0000_0001, "race_read");
        reg_is(`STAT_IDX, 32'h0000_0001, "set_wins");
        reg_is(`STAT_IDX, 32'h0000_0000, "race_clr");
        $display("test race done");
    endtask

    task t_fuse;
        do_reset(1'b1);
        check_bit("det_off", 1'b0, detector_enable);
        xfer(1'b1, `CTRL_IDX, 8'h80);
        repeat (2) @(posedge clk);
        check_bit("det_on", 1'b1, detector_enable);
        check_bit("force_on", 1'b1, pin_drive_force);
        xfer(1'b1, `PMD_IDX, 8'h01);
        repeat (2) @(posedge clk);
        check_bit("det_pmd", 1'b0, detector_enable);
        xfer(1'b1, `CTRL_IDX, 8'h00);
        repeat (2) @(posedge clk);
        check_bit("force_off", 1'b0, pin_drive_force);
        do_reset(1'b0);
        xfer(1'b1, `PMD_IDX, 8'h01);
        repeat (2) @(posedge clk);
        check_bit("det_fuse0", 1'b1, detector_enable);
        $display("test fuse done");
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        av_address = 14'h0000;
        av_read = 1'b0;
        av_write = 1'b0;
        av_writedata = 32'h0000_0000;
        av_byteenable = 4'h0;
        above_ref = 1'b0;
        config_fuse = 1'b0;
        err_count = 0;
        comparisons = 0;
        t_reset_values();
        t_edges();
        t_invert();
        t_race();
        t_fuse();
        give_verdict();
    end
endmodule
`default_nettype wire
